// ### verilog/e8tm_regs.vh
// Constants for the 8-bit match timer channel: register offsets, field positions,
// reset values, mode codes and prescaler masks.
// Assumes a 32-bit APB slave with byte addresses; every register is one aligned word.
`ifndef E8TM_REGS_VH
`define E8TM_REGS_VH

// Register byte offsets
`define E8TM_OFS_MATCH 12'h000
`define E8TM_OFS_MODE 12'h004
`define E8TM_OFS_RUN 12'h008
`define E8TM_OFS_SYS 12'h00C
`define E8TM_OFS_STATUS 12'h010
`define E8TM_OFS_PWM 12'h028

// mode_config_reg fields
`define E8TM_MODE_DBUF 7
`define E8TM_MODE_CLK_HI 6
`define E8TM_MODE_CLK_LO 4
`define E8TM_MODE_OP_HI 3
`define E8TM_MODE_OP_LO 2
`define E8TM_MODE_EVT 1

// run_control_reg fields
`define E8TM_RUN_BIT 0
`define E8TM_RUN_CAS 1

// sys control fields
`define E8TM_SYS_SLOWDIV 0
`define E8TM_SYS_SLOWMODE 1
`define E8TM_SYS_PAIREN 2

// Reset values
`define E8TM_RST_MATCH 8'hFF
`define E8TM_RST_MODE 8'h00
`define E8TM_RST_PWM 8'hFF

// Operating mode codes
`define E8TM_OP_TIMER0 2'h0
`define E8TM_OP_TIMER1 2'h1
`define E8TM_OP_PWM 2'h2

// Gear clock divider masks: tick when the low bits are all ones
`define E8TM_GMASK_2048 11'h7FF
`define E8TM_GMASK_1024 11'h3FF
`define E8TM_GMASK_256 11'h0FF
`define E8TM_GMASK_64 11'h03F
`define E8TM_GMASK_16 11'h00F
`define E8TM_GMASK_4 11'h003
`define E8TM_GMASK_2 11'h001
`define E8TM_GMASK_1 11'h000

// Low-frequency divider masks
`define E8TM_LMASK_16 4'hF
`define E8TM_LMASK_8 4'h7
`define E8TM_LMASK_4 4'h3

// Last count of the PWM period in source ticks (7-bit)
`define E8TM_PWM_LAST 7'h7F

`endif

// ### verilog/e8tm_sync_edge.v
// Two-stage synchroniser with edge strobes for one asynchronous input.
// Assumes the input holds each level for several clk cycles.
`timescale 1ns/10ps
module e8tm_sync_edge (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Asynchronous input
  input wire async_in,
  // Edge strobes, one cycle each
  output wire fall_pulse,
  output wire rise_pulse
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // Only sync_q reads meta_q; last_q holds the previous settled level
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign fall_pulse = last_q & ~sync_q;
  assign rise_pulse = ~last_q & sync_q;

endmodule // e8tm_sync_edge

// ### verilog/e8tm_presc.v
// Prescaler: turns gear_clk (clk itself) or synchronised low_freq_clk edges
// into one-cycle count enables. Assumes lf_tick is already in the clk domain.
`timescale 1ns/10ps
`include "e8tm_regs.vh"
module e8tm_presc (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire enable,
  input wire [2:0] sel,
  input wire slow_div,
  input wire slow_mode,
  input wire lf_tick,
  // Count enable strobe
  output reg tick
);

  reg [10:0] div_q;
  reg [3:0] lf_q;
  reg [10:0] gmask;
  reg [3:0] lmask;
  reg use_lf;
  reg none;

  // Free-running dividers keep the whole counter on one clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 11'h000;
      lf_q <= 4'h0;
    end else if (enable) begin
      div_q <= div_q + 11'h001;
      if (lf_tick) begin
        lf_q <= lf_q + 4'h1;
      end
    end
  end

  // Source selection per speed mode
  always @* begin
    gmask = `E8TM_GMASK_1;
    lmask = `E8TM_LMASK_16;
    use_lf = 1'b0;
    none = 1'b0;
    if (slow_mode) begin
      use_lf = 1'b1;
      case (sel)
        3'h0: lmask = `E8TM_LMASK_16;
        3'h1: lmask = `E8TM_LMASK_8;
        3'h7: lmask = `E8TM_LMASK_4;
        default: none = 1'b1;
      endcase
    end else begin
      case (sel)
        3'h0: begin
          gmask = `E8TM_GMASK_2048;
          use_lf = slow_div;
          lmask = `E8TM_LMASK_16;
        end
        3'h1: begin
          gmask = `E8TM_GMASK_1024;
          use_lf = slow_div;
          lmask = `E8TM_LMASK_8;
        end
        3'h2: gmask = `E8TM_GMASK_256;
        3'h3: gmask = `E8TM_GMASK_64;
        3'h4: gmask = `E8TM_GMASK_16;
        3'h5: gmask = `E8TM_GMASK_4;
        3'h6: gmask = `E8TM_GMASK_2;
        default: gmask = `E8TM_GMASK_1;
      endcase
    end
    if (!enable || none) begin
      tick = 1'b0;
    end else if (use_lf) begin
      tick = lf_tick & ((lf_q & lmask) == lmask);
    end else begin
      tick = ((div_q & gmask) == gmask);
    end
  end

endmodule // e8tm_presc

// ### verilog/e8tm_timer.v
// 8-bit timer channel with match compare, optional double buffer, event
// counter and 7-bit PWM, reached over a 32-bit APB slave.
// Assumes clk is the gear clock; event pin and low_freq_clk are asynchronous.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "e8tm_regs.vh"
module e8tm_timer (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External pins
  input wire event_pin,
  input wire low_freq_clk,
  // Channel outputs
  output reg ch0_match_irq,
  output reg pwm_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [7:0] match_buf_q;
  reg [7:0] match_act_q;
  reg [7:0] mode_q;
  reg ch0_run_q;
  reg cascade_q;
  reg slow_div_q;
  reg slow_mode_q;
  reg pair_en_q;
  reg [7:0] pwm_buf_q;
  reg [7:0] pwm_act_q;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg phase_q;
  reg [31:0] rd_d;
  reg hit_d;

  wire dbuf_enable;
  wire [2:0] src_clk_sel;
  wire [1:0] op_mode_sel;
  wire ext_event_sel;
  wire ev_fall;
  wire lf_rise;
  wire presc_tick;
  wire active;
  wire evt_mode;
  wire pwm_mode;
  wire timer_mode;
  wire count_tick;
  wire wr_acc;
  wire wr_match;
  wire [7:0] wbyte;
  wire [7:0] cnt_inc;
  wire [6:0] duty_field;
  wire extra_pulse_bit;
  wire [7:0] pwm_width;
  wire addr_ok;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign dbuf_enable = mode_q[`E8TM_MODE_DBUF];
  assign src_clk_sel = mode_q[`E8TM_MODE_CLK_HI:`E8TM_MODE_CLK_LO];
  assign op_mode_sel = mode_q[`E8TM_MODE_OP_HI:`E8TM_MODE_OP_LO];
  assign ext_event_sel = mode_q[`E8TM_MODE_EVT];
  assign duty_field = pwm_act_q[7:1];
  assign extra_pulse_bit = pwm_act_q[0];

  // The pair clock gates everything that moves; registers stay writable
  assign active = ch0_run_q & pair_en_q;

  // Mode decode; unlisted combinations (cascade, PPG) leave the counter idle
  assign evt_mode = (op_mode_sel == `E8TM_OP_TIMER0) & ~cascade_q & ext_event_sel;
  assign pwm_mode = (op_mode_sel == `E8TM_OP_PWM) & ~cascade_q & ~ext_event_sel;
  assign timer_mode = ((op_mode_sel == `E8TM_OP_TIMER0) | (op_mode_sel == `E8TM_OP_TIMER1))
    & ~cascade_q & ~ext_event_sel;

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  // Event pin, two flops deep before edge detection
  e8tm_sync_edge u_evt_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(event_pin),
    .fall_pulse(ev_fall),
    .rise_pulse()
  );

  // Low-frequency clock treated as data and sampled the same way
  e8tm_sync_edge u_lf_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(low_freq_clk),
    .fall_pulse(),
    .rise_pulse(lf_rise)
  );

  // Divider runs whenever the pair clock is on
  e8tm_presc u_presc (
    .clk(clk),
    .rstn(rstn),
    .enable(pair_en_q),
    .sel(src_clk_sel),
    .slow_div(slow_div_q),
    .slow_mode(slow_mode_q),
    .lf_tick(lf_rise),
    .tick(presc_tick)
  );

  // Event edges replace the prescaler in event mode
  assign count_tick = active & (evt_mode ? ev_fall : (presc_tick & (timer_mode | pwm_mode)));

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Write lands on the access edge, when pready is already high
  assign wr_acc = psel & penable & pready & pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_match = wr_acc & (paddr == `E8TM_OFS_MATCH);
  assign cnt_inc = cnt_q + 8'h01;
  assign pwm_width = {1'b0, duty_field} + {7'h00, extra_pulse_bit & phase_q};

  // Address check for the error answer only; the read mux decodes paddr itself
  assign addr_ok = (paddr == `E8TM_OFS_MATCH) | (paddr == `E8TM_OFS_MODE) |
    (paddr == `E8TM_OFS_RUN) | (paddr == `E8TM_OFS_SYS) |
    (paddr == `E8TM_OFS_STATUS) | (paddr == `E8TM_OFS_PWM);

  // Read mux; reserved bits read zero
  always @* begin
    rd_d = 32'h0000_0000;
    if (paddr == `E8TM_OFS_MATCH) begin
      rd_d = {24'h000000, match_buf_q};
    end else if (paddr == `E8TM_OFS_MODE) begin
      rd_d = {24'h000000, mode_q};
    end else if (paddr == `E8TM_OFS_RUN) begin
      rd_d = {30'h00000000, cascade_q, ch0_run_q};
    end else if (paddr == `E8TM_OFS_SYS) begin
      rd_d = {29'h00000000, pair_en_q, slow_mode_q, slow_div_q};
    end else if (paddr == `E8TM_OFS_STATUS) begin
      rd_d = {15'h0000, pwm_out, match_act_q, cnt_q};
    end else if (paddr == `E8TM_OFS_PWM) begin
      rd_d = {24'h000000, pwm_buf_q};
    end
  end

  // Setup cycle arms a zero-wait answer; data is captured in the same edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `E8TM_RST_MODE;
      ch0_run_q <= 1'b0;
      cascade_q <= 1'b0;
      slow_div_q <= 1'b0;
      slow_mode_q <= 1'b0;
      pair_en_q <= 1'b0;
      pwm_buf_q <= `E8TM_RST_PWM;
    end else if (wr_acc) begin
      if (paddr == `E8TM_OFS_MODE) begin
        if (!ch0_run_q) begin
          mode_q <= wbyte;
        end
      end else if (paddr == `E8TM_OFS_RUN) begin
        ch0_run_q <= wbyte[`E8TM_RUN_BIT];
        cascade_q <= wbyte[`E8TM_RUN_CAS];
      end else if (paddr == `E8TM_OFS_SYS) begin
        slow_div_q <= wbyte[`E8TM_SYS_SLOWDIV];
        slow_mode_q <= wbyte[`E8TM_SYS_SLOWMODE];
        pair_en_q <= wbyte[`E8TM_SYS_PAIREN];
      end else if (paddr == `E8TM_OFS_PWM) begin
        pwm_buf_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  // Match is judged on the value the counter steps to, so an interval of N
  // ticks needs compare N; on ticks, compare 0 matches on the 256th tick, after a full wrap
  always @* begin
    cnt_d = cnt_q;
    hit_d = 1'b0;
    if (!active) begin
      cnt_d = 8'h00;
    end else if (pwm_mode) begin
      if (count_tick) begin
        cnt_d = (cnt_q[6:0] == `E8TM_PWM_LAST) ? 8'h00 : cnt_inc;
        hit_d = (cnt_q[6:0] == `E8TM_PWM_LAST);
      end
    end else if (wr_match & ~dbuf_enable & (wbyte == cnt_q)) begin
      cnt_d = 8'h00;
      hit_d = 1'b1;
    end else if (count_tick) begin
      if (cnt_inc == match_act_q) begin
        cnt_d = 8'h00;
        hit_d = 1'b1;
      end else begin
        cnt_d = cnt_inc;
      end
    end
  end

  // Counter, interrupt strobe and PWM period phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      ch0_match_irq <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ch0_match_irq <= hit_d;
      if (!active) begin
        phase_q <= 1'b0;
      end else if (pwm_mode & hit_d) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare value and PWM setting buffers
  // ----------------------------------------------------------------
  // The buffer always holds the last write, so reads see it in every mode
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_buf_q <= `E8TM_RST_MATCH;
      match_act_q <= `E8TM_RST_MATCH;
    end else begin
      if (wr_match) begin
        match_buf_q <= wbyte;
      end
      if (wr_match & (~dbuf_enable | ~ch0_run_q)) begin
        match_act_q <= wbyte;
      end else if (hit_d & dbuf_enable & ~pwm_mode) begin
        match_act_q <= match_buf_q;
      end
    end
  end

  // Buffered PWM settings reload at the end of a period, avoiding a torn pulse
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_act_q <= `E8TM_RST_PWM;
    end else if (wr_acc & (paddr == `E8TM_OFS_PWM) & (~dbuf_enable | ~ch0_run_q)) begin
      pwm_act_q <= wbyte;
    end else if (hit_d & pwm_mode & dbuf_enable) begin
      pwm_act_q <= pwm_buf_q;
    end
  end

  // ----------------------------------------------------------------
  // PWM output
  // ----------------------------------------------------------------
  // High from period start for the duty width; low when not in PWM mode
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out <= 1'b0;
    end else if (active & pwm_mode) begin
      pwm_out <= ({1'b0, cnt_d[6:0]} < pwm_width);
    end else begin
      pwm_out <= 1'b0;
    end
  end

endmodule // e8tm_timer

// ### tb/e8tm_event_src.sv
// Event pulse source standing on the counter's input pin.
// Assumes clk is the bench gear clock; the pin idles high and falls are counted.
`timescale 1ns/10ps
module e8tm_event_src (
  // Clock
  input wire clk,
  // Event pin
  output logic event_pin
);
  // Idle level high so that the first fall is a real event
  initial event_pin = 1'b1;

  // Each level is held at least two cycles so the pin synchroniser never misses one
  task automatic pulses(input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      @(posedge clk);
      event_pin <= 1'b0;
      repeat (h) @(posedge clk);
      event_pin <= 1'b1;
      repeat (h - 1) @(posedge clk);
    end
  endtask
endmodule // e8tm_event_src

// ### tb/e8tm_timer_checker.sv
// Port checker for the 8-bit match timer; keeps its own shadow of register writes.
// Assumes the register byte offsets of the timer header and one clock domain.
`timescale 1ns/10ps
module e8tm_timer_checker (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Channel outputs
  input wire ch0_match_irq,
  input wire pwm_out
);
  logic [7:0] match_q, mode_q, pwm_q;
  logic run_q, pair_q;
  wire wr_go = psel && penable && pready && pwrite;
  wire rd_go = psel && penable && pready && !pwrite;
  wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C ||
    paddr == 12'h010 || paddr == 12'h028;

  // Shadows of software writes; mode is frozen while running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_q <= 8'hFF;
      mode_q <= 8'h00;
      pwm_q <= 8'hFF;
      run_q <= 1'b0;
      pair_q <= 1'b0;
    end else if (wr_go) begin
      if (paddr == 12'h000) match_q <= pwdata[7:0];
      if (paddr == 12'h004 && !run_q) mode_q <= pwdata[7:0];
      if (paddr == 12'h028) pwm_q <= pwdata[7:0];
      if (paddr == 12'h008) run_q <= pwdata[0];
      if (paddr == 12'h00C) pair_q <= pwdata[2];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_setup_answer: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
  chk_unmapped_err: assert property (psel && pready |-> pslverr == !mapped) else $error("bad slave error");
  chk_match_readback: assert property (rd_go && paddr == 12'h000 |-> prdata == {24'h000000, match_q})
    else $error("match read differs from last write");
  chk_mode_locked: assert property (rd_go && paddr == 12'h004 |-> prdata == {24'h000000, mode_q})
    else $error("mode changed while running");
  chk_pwm_readback: assert property (rd_go && paddr == 12'h028 |-> prdata == {24'h000000, pwm_q})
    else $error("pwm setting read differs");
  chk_irq_gated: assert property ((!pair_q) [*3] |-> !ch0_match_irq) else $error("irq without pair clock");
  chk_pwm_gated: assert property ((!pair_q) [*3] |-> !pwm_out) else $error("pwm without pair clock");
  chk_stop_quiet: assert property ((!run_q) [*3] |-> !ch0_match_irq) else $error("irq while stopped");
endmodule // e8tm_timer_checker

bind e8tm_timer e8tm_timer_checker e8tm_timer_checker_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .ch0_match_irq, .pwm_out);

// ### tb/e8tm_timer_tb.sv
// Bench for the 8-bit match timer: APB master, clocks and one task per scenario.
// Assumes the checker binds itself and the event source model drives the pin.
`timescale 1ns/10ps
module e8tm_timer_tb;
  logic clk, rstn, psel, penable, pwrite, lf_clk, err_q, pready, pslverr, event_pin, irq, pwm_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  e8tm_timer e8tm_timer_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pin(event_pin), .low_freq_clk(lf_clk), .ch0_match_irq(irq), .pwm_out(pwm_out));
  e8tm_event_src e8tm_event_src_i (.clk(clk), .event_pin(event_pin));

  // Gear clock 4 ns; low-frequency clock ten gear periods, offset so edges never coincide
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lf_clk = 1'b0;
    #1;
    forever #20 lf_clk = ~lf_clk;
  end

  // Watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Cycles up to and including the next irq pulse, bounded
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (irq !== 1'b1 && c < 10000);
  endtask
  task automatic start(input logic [7:0] mode, input logic [7:0] m);
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b1, 12'h004, mode);
    apb(1'b1, 12'h000, m);
    apb(1'b1, 12'h008, 8'h01);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset();
    apb(1'b0, 12'h000, 8'h00);
    check("match reset", 32'hFF, rd_q);
    apb(1'b0, 12'h028, 8'h00);
    check("pwm reset", 32'hFF, rd_q);
    apb(1'b1, 12'h028, 8'h5A);
    apb(1'b0, 12'h028, 8'h00);
    check("pwm rw", 32'h5A, rd_q);
    apb(1'b0, 12'h014, 8'h00);
    check("unmapped error", 32'h1, err_q);
    start(8'h70, 8'h03);
    repeat (20) @(posedge clk);
    apb(1'b0, 12'h010, 8'h00);
    check("count without pair clock", 32'h0, rd_q[7:0]);
  endtask
  // Every source code, then low-frequency divide 16 and 8 via slow_div and 4 via slow_mode; compare 2 gives two ticks
  task automatic s_presc();
    int dv [11] = '{2048, 1024, 256, 64, 16, 4, 2, 1, 160, 80, 40};
    logic [7:0] sy [11] = '{4, 4, 4, 4, 4, 4, 4, 4, 5, 5, 6};
    logic [2:0] cd [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 1, 7};
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, 12'h00C, sy[i]);
      start({1'b0, cd[i], 4'h0}, 8'h02);
      wait_irq(n);
      wait_irq(n);
      check("tick interval", 2 * dv[i], n);
    end
    apb(1'b1, 12'h00C, 8'h04);
  endtask
  task automatic s_stop();
    start(8'h70, 8'hC8);
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    check("mode locked", 32'h70, rd_q);
    apb(1'b0, 12'h010, 8'h00);
    check("count runs", 32'h1, rd_q[7:0] != 8'h00);
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b0, 12'h010, 8'h00);
    check("count cleared", 32'h0, rd_q[7:0]);
  endtask
  task automatic s_dbuf();
    apb(1'b1, 12'h004, 8'hF0);
    apb(1'b1, 12'h000, 8'h64);
    apb(1'b0, 12'h010, 8'h00);
    check("compare stopped write", 32'h64, rd_q[15:8]);
    apb(1'b1, 12'h008, 8'h01);
    apb(1'b1, 12'h000, 8'h32);
    apb(1'b0, 12'h010, 8'h00);
    check("compare held", 32'h64, rd_q[15:8]);
    apb(1'b0, 12'h000, 8'h00);
    check("match read", 32'h32, rd_q);
    wait_irq(n);
    apb(1'b0, 12'h010, 8'h00);
    check("compare loaded", 32'h32, rd_q[15:8]);
    wait_irq(n);
    wait_irq(n);
    check("new interval", 32'd50, n);
  endtask
  // Unbuffered value below the count must wait for the wrap
  task automatic s_nobuf();
    start(8'h40, 8'hC8);
    repeat (400) @(posedge clk);
    apb(1'b1, 12'h000, 8'h05);
    apb(1'b0, 12'h010, 8'h00);
    check("compare at once", 32'h05, rd_q[15:8]);
    wait_irq(n);
    check("wait past wrap", 32'h1, n > 3000 && n < 5000);
  endtask
  // Compare written equal to the resting count at the slowest source matches at once
  task automatic s_equal();
    start(8'h00, 8'hC8);
    apb(1'b1, 12'h000, 8'h00);
    wait_irq(n);
    check("equal write match", 32'h1, n);
    apb(1'b0, 12'h010, 8'h00);
    check("equal write clears", 32'h0, rd_q[7:0]);
    apb(1'b1, 12'h008, 8'h00);
  endtask
  task automatic s_event();
    start(8'h02, 8'h03);
    fork
      e8tm_event_src_i.pulses(3, 2);
      wait_irq(n);
    join
    check("event match", 32'h1, n < 200);
    apb(1'b0, 12'h010, 8'h00);
    check("event count cleared", 32'h0, rd_q[7:0]);
    e8tm_event_src_i.pulses(2, 3);
    repeat (6) @(posedge clk);
    apb(1'b0, 12'h010, 8'h00);
    check("event count continues", 32'h2, rd_q[7:0]);
  endtask
  // Two periods of 128 ticks: duty twice, plus one when the extra bit is set
  task automatic s_pwm(input logic [7:0] v, input int e);
    int hi;
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b1, 12'h028, v);
    start(8'h78, 8'hFF);
    wait_irq(n);
    hi = 0;
    repeat (256) begin
      @(posedge clk);
      hi += (pwm_out === 1'b1);
    end
    check("pwm high cycles", e, hi);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    s_reset();
    s_presc();
    s_stop();
    s_dbuf();
    s_nobuf();
    s_equal();
    s_event();
    s_pwm(8'h40, 64);
    s_pwm(8'h41, 65);
    give_verdict();
  end
endmodule // e8tm_timer_tb
